/* File: design/ssc_pkg.sv */
// constants and types for the sleep, standby and clock control block
package ssc_pkg;
  // register indices as printed, byte address is four times the index
  localparam logic [7:0] CLOCK_MULTIPLIER_CTRL_IDX      = 8'h1E;
  localparam logic [7:0] PROCESSOR_CLOCK_POWER_CTRL_IDX = 8'h1F;
  localparam logic [7:0] IRQ_ENABLE_CTRL_IDX            = 8'h20;
  localparam logic [7:0] SLEEP_STATUS_IDX               = 8'h21;

  // clock multiplier register fields
  localparam int        CMR_DOUBLER_BIT   = 7;
  localparam logic [7:0] CMR_RESERVED_READ = 8'h7F;

  // processor clock and power register fields
  localparam int        CCR_CLOCK_DIVIDE_BIT = 7;
  localparam int        CCR_LP_HIGH_BIT      = 6;
  localparam int        CCR_BUS_REQUEST_INPUT_EXIT_BIT  = 5;
  localparam int        CCR_LOW_DRIVE_BIT    = 4;
  localparam int        CCR_LP_LOW_BIT       = 3;
  localparam logic [7:0] CCR_RESET           = 8'h00;

  // interrupt enable register: bits 4..0 per source, bit 7 global flag
  localparam int        IEN_GLOBAL_BIT = 7;
  localparam int        NUM_MASKABLE   = 5;
  localparam logic [7:0] IEN_RESET     = 8'h00;

  // low-power select codes {bit6, bit3}
  localparam logic [1:0] LP_NONE          = 2'h0;
  localparam logic [1:0] LP_IDLE          = 2'h1;
  localparam logic [1:0] LP_STANDBY       = 2'h2;
  localparam logic [1:0] LP_STANDBY_QUICK = 2'h3;

  // reset pin must be held low this many cycles to leave sleep
  localparam logic [2:0] RESET_EXIT_CYCLES = 3'h6;
  // wake-up delays out of standby, in system clock cycles
  localparam logic [10:0] QUICK_RECOVERY_CYCLES   = 11'h040;
  localparam logic [10:0] STANDBY_RECOVERY_CYCLES = 11'h400;

  // restart address after a reset exit
  localparam logic [19:0] RESET_START_ADDR = 20'h00000;

  typedef enum logic [1:0] {
    SSC_RUN,
    SSC_SLEEP,
    SSC_RECOVER
  } ssc_state_t;

  typedef enum logic [2:0] {
    SSC_CAUSE_NONE,
    SSC_CAUSE_RESET,
    SSC_CAUSE_NMI,
    SSC_CAUSE_IRQ,
    SSC_CAUSE_RESUME
  } ssc_cause_t;
endpackage : ssc_pkg

/* File: design/ssc_sleep_ctrl.sv */
// sleep exit, low-power mode and clock control with an ahb-lite register slave
`timescale 1ns/1ps

// Notes on behaviour
// R1: reset pin low six cycles restarts at zero
// R2: enabled external or on-chip request wakes core
// R3: nmi always wakes, takes nmi response
// R4: individually disabled source ignored, stays asleep
// R5: enabled source, global flag set: interrupt response
// R6: enabled source, global flag clear: resume next
// R7: multiplier bit 7 enables doubler, rest reserved
// R8: control bit 7 selects crystal divide by one/two
// R9: bits 6,3 select none, idle, standby, quick standby
// R10: bit 5 lets bus request leave standby/idle
// R11: bit 4 selects reduced clock output drive
// R12: sleep instruction halts fetch until exit
module ssc_sleep_ctrl (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // core and pins
  input  wire logic        i_sleep_instruction,
  input  wire logic        i_reset_pin_n,
  input  wire logic        i_nmi_req,
  input  wire logic [4:0]  i_irq_req,
  input  wire logic        i_bus_request_input,
  // wake results
  output logic             o_fetch_halt,
  output logic             o_reset_restart,
  output logic [19:0]      o_restart_addr,
  output logic             o_nmi_response,
  output logic             o_irq_response,
  output logic [2:0]       o_irq_source,
  output logic             o_resume_next,
  // clock and power control
  output logic             o_core_clk_en,
  output logic             o_clock_doubler_enable,
  output logic             o_crystal_undivided,
  output logic             o_idle,
  output logic             o_standby,
  output logic             o_sysclk_output_low_drive
);

  // lowest index wins among pending enabled sources
  function automatic logic [2:0] ssc_first(input logic [4:0] req);
    logic [2:0] idx;
    idx = 3'h0;
    for (int k = ssc_pkg::NUM_MASKABLE - 1; k >= 0; k--) begin
      if (req[k]) begin
        idx = 3'(k);
      end
    end
    return idx;
  endfunction : ssc_first

  // word address of a byte address, only the index range is decoded
  function automatic logic [7:0] ssc_index(input logic [31:0] addr);
    return addr[9:2];
  endfunction : ssc_index

  // ---------------- bus slave ----------------
  logic       wr_pend_q, wr_pend_d;
  logic [7:0] wr_idx_q, wr_idx_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] cmr_q, cmr_d;
  logic [7:0] ccr_q, ccr_d;
  logic [7:0] ien_q, ien_d;
  logic [7:0] status_byte;
  logic       addr_ok;
  logic       ready_q, ready_d;
  logic       resp_q, resp_d;

  ssc_pkg::ssc_state_t state_q, state_d;
  ssc_pkg::ssc_cause_t cause_q, cause_d;

  // hsize is not decoded: only whole-word transfers are supported
  assign addr_ok = i_hsel && i_hready && i_htrans[1] && (i_haddr[1:0] == 2'h0);

  always_comb begin
    wr_pend_d = 1'b0;
    wr_idx_d  = wr_idx_q;
    rdata_d   = rdata_q;
    cmr_d     = cmr_q;
    ccr_d     = ccr_q;
    ien_d     = ien_q;
    // no wait states and no error answers, held in flops like every other output
    ready_d   = 1'b1;
    resp_d    = 1'b0;
    // data phase write lands one edge after the address phase
    if (wr_pend_q) begin
      case (wr_idx_q)
        ssc_pkg::CLOCK_MULTIPLIER_CTRL_IDX: begin
          cmr_d[ssc_pkg::CMR_DOUBLER_BIT] = i_hwdata[ssc_pkg::CMR_DOUBLER_BIT]; // R7
        end
        ssc_pkg::PROCESSOR_CLOCK_POWER_CTRL_IDX: begin
          ccr_d = i_hwdata[7:0]; // R8 R9 R10 R11
        end
        ssc_pkg::IRQ_ENABLE_CTRL_IDX: begin
          ien_d = i_hwdata[7:0];
        end
        default: begin
          ien_d = ien_q;
        end
      endcase
    end
    if (addr_ok && i_hwrite) begin
      wr_pend_d = 1'b1;
      wr_idx_d  = ssc_index(i_haddr);
    end
    // zero-wait reads: data captured at the address phase edge
    // next values are read so that a read right behind a write sees the new data
    if (addr_ok && !i_hwrite) begin
      case (ssc_index(i_haddr))
        ssc_pkg::CLOCK_MULTIPLIER_CTRL_IDX: begin
          rdata_d = {24'h000000, cmr_d[ssc_pkg::CMR_DOUBLER_BIT], ssc_pkg::CMR_RESERVED_READ[6:0]};
        end
        ssc_pkg::PROCESSOR_CLOCK_POWER_CTRL_IDX: begin
          rdata_d = {24'h000000, ccr_d};
        end
        ssc_pkg::IRQ_ENABLE_CTRL_IDX: begin
          rdata_d = {24'h000000, ien_d};
        end
        ssc_pkg::SLEEP_STATUS_IDX: begin
          rdata_d = {24'h000000, status_byte};
        end
        default: begin
          rdata_d = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
      rdata_q   <= 32'h00000000;
      cmr_q     <= 8'h00;
      ccr_q     <= ssc_pkg::CCR_RESET;
      ien_q     <= ssc_pkg::IEN_RESET;
      ready_q   <= 1'b1;
      resp_q    <= 1'b0;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_idx_q  <= wr_idx_d;
      rdata_q   <= rdata_d;
      cmr_q     <= cmr_d;
      ccr_q     <= ccr_d;
      ien_q     <= ien_d;
      ready_q   <= ready_d;
      resp_q    <= resp_d;
    end
  end

  // ---------------- sleep sequencer ----------------
  logic [1:0]  lp_mode;
  logic [1:0]  lp_sel_q, lp_sel_d;
  logic [2:0]  rst_cnt_q, rst_cnt_d;
  logic [10:0] rec_cnt_q, rec_cnt_d;
  logic [2:0]  src_q, src_d;
  logic [19:0] restart_q, restart_d;
  logic [4:0]  enabled_req;
  logic        global_en;
  logic        bus_request_input_release;
  logic        reset_pulse_d, nmi_pulse_d, irq_pulse_d, resume_pulse_d;
  logic        reset_pulse_q, nmi_pulse_q, irq_pulse_q, resume_pulse_q;

  assign lp_mode     = {ccr_q[ssc_pkg::CCR_LP_HIGH_BIT], ccr_q[ssc_pkg::CCR_LP_LOW_BIT]}; // R9
  assign enabled_req = i_irq_req & ien_q[4:0]; // R4
  assign global_en   = ien_q[ssc_pkg::IEN_GLOBAL_BIT];
  // a bus request only lifts standby/idle when enabled, the core stays asleep
  assign bus_request_input_release = ccr_q[ssc_pkg::CCR_BUS_REQUEST_INPUT_EXIT_BIT] && i_bus_request_input; // R10
  assign status_byte = {1'b0, 3'(cause_q), lp_sel_q, 2'(state_q)};

  always_comb begin
    state_d        = state_q;
    cause_d        = cause_q;
    lp_sel_d       = lp_sel_q;
    rst_cnt_d      = 3'h0;
    rec_cnt_d      = rec_cnt_q;
    src_d          = src_q;
    // restart address is fixed, but kept in a flop like the other outputs
    restart_d      = ssc_pkg::RESET_START_ADDR; // R1
    reset_pulse_d  = 1'b0;
    nmi_pulse_d    = 1'b0;
    irq_pulse_d    = 1'b0;
    resume_pulse_d = 1'b0;
    case (state_q)
      ssc_pkg::SSC_RUN: begin
        if (i_sleep_instruction) begin
          state_d  = ssc_pkg::SSC_SLEEP; // R12
          lp_sel_d = lp_mode;
        end
      end
      ssc_pkg::SSC_SLEEP: begin
        // any high sample clears the count, so short glitches never restart the core
        if (!i_reset_pin_n) begin
          rst_cnt_d = rst_cnt_q + 3'h1;
        end
        if (!i_reset_pin_n && (rst_cnt_q == ssc_pkg::RESET_EXIT_CYCLES - 3'h1)) begin
          // reset exit skips any standby recovery delay
          state_d       = ssc_pkg::SSC_RUN; // R1
          cause_d       = ssc_pkg::SSC_CAUSE_RESET;
          reset_pulse_d = 1'b1;
          rst_cnt_d     = 3'h0;
        end else if (i_nmi_req || (enabled_req != 5'h00)) begin
          // nmi outranks maskable sources and ignores every enable
          if (i_nmi_req) begin
            cause_d = ssc_pkg::SSC_CAUSE_NMI; // R3
          end else if (global_en) begin
            cause_d = ssc_pkg::SSC_CAUSE_IRQ; // R5
          end else begin
            cause_d = ssc_pkg::SSC_CAUSE_RESUME; // R6
          end
          src_d = ssc_first(enabled_req); // R2
          if (lp_sel_q == ssc_pkg::LP_STANDBY_QUICK) begin
            state_d   = ssc_pkg::SSC_RECOVER;
            rec_cnt_d = ssc_pkg::QUICK_RECOVERY_CYCLES - 11'h001; // R9
          end else if (lp_sel_q == ssc_pkg::LP_STANDBY) begin
            state_d   = ssc_pkg::SSC_RECOVER;
            rec_cnt_d = ssc_pkg::STANDBY_RECOVERY_CYCLES - 11'h001;
          end else begin
            state_d = ssc_pkg::SSC_RUN;
            if (i_nmi_req) begin
              nmi_pulse_d = 1'b1;
            end else if (global_en) begin
              irq_pulse_d = 1'b1;
            end else begin
              resume_pulse_d = 1'b1;
            end
          end
        end
      end
      ssc_pkg::SSC_RECOVER: begin
        // oscillator restart time; requests that arrive now wait for the response
        // the reset pin is not watched here or in run; only the sleep state counts its low samples
        if (rec_cnt_q == 11'h000) begin
          state_d        = ssc_pkg::SSC_RUN;
          nmi_pulse_d    = (cause_q == ssc_pkg::SSC_CAUSE_NMI);
          irq_pulse_d    = (cause_q == ssc_pkg::SSC_CAUSE_IRQ);
          resume_pulse_d = (cause_q == ssc_pkg::SSC_CAUSE_RESUME);
        end else begin
          rec_cnt_d = rec_cnt_q - 11'h001;
        end
      end
      default: begin
        state_d = ssc_pkg::SSC_RUN;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_q        <= ssc_pkg::SSC_RUN;
      cause_q        <= ssc_pkg::SSC_CAUSE_NONE;
      lp_sel_q       <= ssc_pkg::LP_NONE;
      rst_cnt_q      <= 3'h0;
      rec_cnt_q      <= 11'h000;
      src_q          <= 3'h0;
      restart_q      <= ssc_pkg::RESET_START_ADDR;
      reset_pulse_q  <= 1'b0;
      nmi_pulse_q    <= 1'b0;
      irq_pulse_q    <= 1'b0;
      resume_pulse_q <= 1'b0;
    end else begin
      state_q        <= state_d;
      cause_q        <= cause_d;
      lp_sel_q       <= lp_sel_d;
      rst_cnt_q      <= rst_cnt_d;
      rec_cnt_q      <= rec_cnt_d;
      src_q          <= src_d;
      restart_q      <= restart_d;
      reset_pulse_q  <= reset_pulse_d;
      nmi_pulse_q    <= nmi_pulse_d;
      irq_pulse_q    <= irq_pulse_d;
      resume_pulse_q <= resume_pulse_d;
    end
  end

  // ---------------- clock and power outputs ----------------
  logic div_q, div_d;
  logic clk_en_q, clk_en_d;
  logic idle_q, idle_d;
  logic standby_q, standby_d;
  logic halt_q, halt_d;

  always_comb begin
    // the divider free-runs, so the first enabled cycle after a wake may wait one cycle
    div_d     = ~div_q;
    // undivided or doubled crystal runs the core every master cycle
    clk_en_d  = (state_d == ssc_pkg::SSC_RUN) &&
                (ccr_q[ssc_pkg::CCR_CLOCK_DIVIDE_BIT] || cmr_q[ssc_pkg::CMR_DOUBLER_BIT] || div_q); // R8 R7
    idle_d    = (state_d == ssc_pkg::SSC_SLEEP) && (lp_sel_d == ssc_pkg::LP_IDLE) && !bus_request_input_release; // R9 R10
    standby_d = (state_d == ssc_pkg::SSC_SLEEP) && lp_sel_d[1] && !bus_request_input_release; // R9 R10
    halt_d    = (state_d != ssc_pkg::SSC_RUN); // R12
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      div_q     <= 1'b0;
      clk_en_q  <= 1'b0;
      idle_q    <= 1'b0;
      standby_q <= 1'b0;
      halt_q    <= 1'b0;
    end else begin
      div_q     <= div_d;
      clk_en_q  <= clk_en_d;
      idle_q    <= idle_d;
      standby_q <= standby_d;
      halt_q    <= halt_d;
    end
  end

  assign o_hrdata                  = rdata_q;
  assign o_hreadyout               = ready_q;
  assign o_hresp                   = resp_q;
  assign o_fetch_halt              = halt_q;
  assign o_reset_restart           = reset_pulse_q;
  assign o_restart_addr            = restart_q; // R1
  assign o_nmi_response            = nmi_pulse_q;
  assign o_irq_response            = irq_pulse_q;
  assign o_irq_source              = src_q;
  assign o_resume_next             = resume_pulse_q;
  assign o_core_clk_en             = clk_en_q;
  assign o_clock_doubler_enable    = cmr_q[ssc_pkg::CMR_DOUBLER_BIT]; // R7
  assign o_crystal_undivided       = ccr_q[ssc_pkg::CCR_CLOCK_DIVIDE_BIT]; // R8
  assign o_idle                    = idle_q;
  assign o_standby                 = standby_q;
  assign o_sysclk_output_low_drive = ccr_q[ssc_pkg::CCR_LOW_DRIVE_BIT]; // R11

endmodule : ssc_sleep_ctrl

/* File: tb/ssc_chk_assertions.sv */
// assertion checker bound to the sleep and clock control block
`timescale 1ns/1ps
module ssc_chk (
  // clock and reset
  input wire logic        i_mclk,
  input wire logic        i_rst,
  // requests
  input wire logic        i_sleep_instruction,
  input wire logic        i_reset_pin_n,
  input wire logic        i_nmi_req,
  input wire logic [4:0]  i_irq_req,
  // outputs watched
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic [19:0] o_restart_addr,
  input wire logic        o_fetch_halt,
  input wire logic        o_reset_restart,
  input wire logic        o_nmi_response,
  input wire logic        o_irq_response,
  input wire logic        o_resume_next,
  input wire logic        o_core_clk_en,
  input wire logic        o_clock_doubler_enable,
  input wire logic        o_crystal_undivided,
  input wire logic        o_idle,
  input wire logic        o_standby
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  logic wake_any;
  assign wake_any = o_reset_restart | o_nmi_response | o_irq_response | o_resume_next;

  chk_bus_okay: assert property (o_hreadyout && !o_hresp) else $error("bus answer not ready okay");
  chk_restart_zero: assert property (o_reset_restart |-> o_restart_addr == 20'h00000)
    else $error("restart address not zero");
  chk_reset_hold: assert property (o_reset_restart |-> !$past(i_reset_pin_n, 1) && !$past(i_reset_pin_n, 6))
    else $error("restart without six low cycles");
  chk_nmi_wake: assert property (o_idle && i_nmi_req && i_reset_pin_n |=> o_nmi_response)
    else $error("nmi did not wake");
  chk_wake_once: assert property ($onehot0({o_reset_restart, o_nmi_response, o_irq_response, o_resume_next}))
    else $error("two wake results at once");
  chk_wake_halt: assert property (wake_any |-> $past(o_fetch_halt) ##1 !o_fetch_halt)
    else $error("fetch halt wrong around wake");
  chk_sleep_entry: assert property (!o_fetch_halt && i_sleep_instruction |=> o_fetch_halt)
    else $error("sleep not entered");
  chk_asleep_clk: assert property (o_idle || o_standby |-> !o_core_clk_en)
    else $error("core clock runs while asleep");
  chk_clk_half: assert property (!o_crystal_undivided && !o_clock_doubler_enable && o_core_clk_en
    && !$past(o_crystal_undivided) && !$past(o_clock_doubler_enable) |=> !o_core_clk_en)
    else $error("divided clock enable two cycles in a row");
  chk_clk_full: assert property (!o_fetch_halt && ($past(o_crystal_undivided) || $past(o_clock_doubler_enable))
    |-> o_core_clk_en)
    else $error("full rate clock enable missing");
  chk_irq_cause: assert property ((o_irq_response || o_resume_next) && $past(o_idle)
    |-> $past(i_irq_req) != 5'h00 && !$past(i_nmi_req))
    else $error("maskable wake without request");
endmodule : ssc_chk

bind ssc_sleep_ctrl ssc_chk chk_u (.*);

/* File: tb/ssc_far_side.sv */
// far-side model: interrupt sources, reset pin and bus requester
`timescale 1ns/1ps
module ssc_far_side (
  // clock
  input  wire logic  i_mclk,
  // requests toward the block
  output logic       o_reset_pin_n,
  output logic       o_nmi_req,
  output logic [4:0] o_irq_req,
  output logic       o_bus_request_input
);
  // reset pin rests high as if pulled up
  initial begin
    o_reset_pin_n = 1'b1;
    o_nmi_req = 1'b0;
    o_irq_req = 5'h00;
    o_bus_request_input = 1'b0;
  end
  // levels move just after an edge so no half-set request is ever sampled
  task automatic drive(input logic nmi, input logic [4:0] irq, input logic breq);
    @(posedge i_mclk);
    o_nmi_req <= nmi;
    o_irq_req <= irq;
    o_bus_request_input <= breq;
  endtask : drive
  // pin low for exactly n sampling edges
  task automatic hold_reset(input int n);
    @(posedge i_mclk);
    o_reset_pin_n <= 1'b0;
    repeat (n) @(posedge i_mclk);
    o_reset_pin_n <= 1'b1;
  endtask : hold_reset
endmodule : ssc_far_side

/* File: tb/tb.sv */
// self-checking bench: register access and sleep exits
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e); end end
module tb;
  localparam logic [7:0] MUL = ssc_pkg::CLOCK_MULTIPLIER_CTRL_IDX;
  localparam logic [7:0] PWR = ssc_pkg::PROCESSOR_CLOCK_POWER_CTRL_IDX;
  localparam logic [7:0] IEN = ssc_pkg::IRQ_ENABLE_CTRL_IDX;
  logic        i_mclk, i_rst, i_hsel, i_hwrite, i_sleep_instruction;
  logic [31:0] i_haddr, i_hwdata, rd;
  logic [1:0]  i_htrans;
  logic [2:0]  i_hsize;
  logic [3:0]  p;
  wire logic   i_hready, i_reset_pin_n, i_nmi_req, i_bus_request_input;
  wire logic   o_hreadyout, o_hresp, o_fetch_halt, o_reset_restart, o_nmi_response, o_irq_response;
  wire logic   o_resume_next, o_core_clk_en, o_clock_doubler_enable, o_crystal_undivided;
  wire logic   o_idle, o_standby, o_sysclk_output_low_drive;
  wire logic [31:0] o_hrdata;
  wire logic [19:0] o_restart_addr;
  wire logic [4:0]  i_irq_req;
  wire logic [2:0]  o_irq_source;
  int n_fail, comparisons, n, base;
  assign i_hready = o_hreadyout;
  ssc_sleep_ctrl dut_u (.*);
  ssc_far_side far_u (.i_mclk(i_mclk), .o_reset_pin_n(i_reset_pin_n), .o_nmi_req(i_nmi_req),
    .o_irq_req(i_irq_req), .o_bus_request_input(i_bus_request_input));
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  task automatic conclude;
    if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic tmo;
    n_fail++;
    $display("CHECK FAILED %0t wait timed out", $time);
    conclude();
  endtask : tmo
  task automatic hwait;
    int k;
    k = 0;
    do begin
      @(posedge i_mclk);
      k++;
    end while (i_hready !== 1'b1 && k < 20);
    if (k >= 20) tmo();
  endtask : hwait
  // one single word transfer: address phase, then data phase
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
    @(posedge i_mclk);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= {22'h000000, idx, 2'h0};
    i_hwrite <= wr;
    hwait();
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    hwait();
    rd = o_hrdata;
    i_hsel <= 1'b0;
  endtask : bus
  task automatic nap;
    @(posedge i_mclk);
    i_sleep_instruction <= 1'b1;
    @(posedge i_mclk);
    i_sleep_instruction <= 1'b0;
    repeat (3) @(posedge i_mclk);
  endtask : nap
  // long enough for the slow standby recovery
  task automatic wake;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
      p = {o_reset_restart, o_nmi_response, o_irq_response, o_resume_next};
    end while (p === 4'h0 && n < 1200);
    if (n >= 1200) tmo();
  endtask : wake
  initial begin
    {i_rst, i_hsel, i_hwrite, i_sleep_instruction, i_haddr, i_hwdata, i_htrans} = {1'b1, 69'h0};
    i_hsize = 3'h2;
    repeat (20) @(posedge i_mclk);
    i_rst <= 1'b0;
    bus(PWR, 1'b0, 32'h0);
    `CHK(rd, 32'h00000000)
    bus(MUL, 1'b0, 32'h0);
    `CHK(rd, 32'h0000007F)
    bus(MUL, 1'b1, 32'hFFFFFFFF);
    bus(MUL, 1'b0, 32'h0);
    `CHK(rd, 32'h000000FF)
    `CHK(o_clock_doubler_enable, 1'b1)
    bus(MUL, 1'b1, 32'h0);
    bus(PWR, 1'b1, 32'h90);
    bus(PWR, 1'b0, 32'h0);
    `CHK(rd, 32'h00000090)
    `CHK({o_crystal_undivided, o_sysclk_output_low_drive}, 2'h3)
    bus(8'h10, 1'b1, 32'hFF);
    bus(8'h10, 1'b0, 32'h0);
    `CHK(rd, 32'h00000000)
    bus(PWR, 1'b1, 32'h08);
    // every source, global flag off then on, all other sources raised but masked
    for (int s = 0; s < 10; s++) begin
      bus(IEN, 1'b1, {24'h0, s[0], 2'h0, 5'h01 << (s / 2)});
      nap();
      far_u.drive(1'b0, 5'h1F ^ (5'h01 << (s / 2)), 1'b0);
      repeat (5) @(posedge i_mclk);
      `CHK(o_fetch_halt, 1'b1)
      far_u.drive(1'b0, 5'h1F, 1'b0);
      wake();
      `CHK(p, s[0] ? 4'h2 : 4'h1)
      if (s[0]) `CHK(o_irq_source, 3'(s / 2))
      far_u.drive(1'b0, 5'h00, 1'b0);
    end
    bus(IEN, 1'b1, 32'h0);
    // each low-power mode, nmi with every enable cleared
    for (int m = 0; m < 4; m++) begin
      bus(PWR, 1'b1, {24'h0, 1'b0, m[1], 2'h0, m[0], 3'h0});
      nap();
      `CHK({o_idle, o_standby}, {m == 1, m[1]})
      far_u.drive(1'b1, 5'h00, 1'b0);
      wake();
      `CHK(p, 4'h4)
      if (m == 0) base = n;
      `CHK(n, base + (m < 2 ? 0 : m == 3 ? 64 : 1024))
      far_u.drive(1'b0, 5'h00, 1'b0);
    end
    for (int b = 0; b < 2; b++) begin
      bus(PWR, 1'b1, {24'h0, 2'h0, b[0], 5'h08});
      nap();
      far_u.drive(1'b0, 5'h00, 1'b1);
      repeat (3) @(posedge i_mclk);
      `CHK({o_idle, o_fetch_halt}, {~b[0], 1'b1})
      far_u.drive(1'b1, 5'h00, 1'b0);
      wake();
      `CHK(p, 4'h4)
      far_u.drive(1'b0, 5'h00, 1'b0);
    end
    nap();
    far_u.hold_reset(5);
    repeat (3) @(posedge i_mclk);
    `CHK(o_fetch_halt, 1'b1)
    far_u.hold_reset(6);
    wake();
    `CHK(p, 4'h8)
    `CHK(o_restart_addr, ssc_pkg::RESET_START_ADDR)
    conclude();
  end
endmodule : tb
